// File: rtl/oamd_regs.svh
// constants of the operand addressing mode decoder
`ifndef OAMD_REGS_SVH
`define OAMD_REGS_SVH
`define OAMD_GEN_REG_TOP  5'h07
`define OAMD_GEN_RSVD     5'h13
`define OAMD_GEN_IMM      5'h14
`define OAMD_IDX_MODE_MSB 7
`define OAMD_IDX_MODE_LSB 3
`define OAMD_IDX_REG_MSB  2
`define OAMD_DLEN_1       4'h1
`define OAMD_DLEN_2       4'h2
`define OAMD_DLEN_4       4'h4
`define OAMD_STEP_FIN     3'h5
`define OAMD_STEP_IMPL    3'h4
`endif

// File: rtl/oamd_pkg.sv
// types of the operand addressing mode decoder
package oamd_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_SEEK = 5'h02,
    S_IDX  = 5'h04,
    S_DISP = 5'h08,
    S_IMM  = 5'h10
  } oamd_state_t;

  typedef enum logic [3:0] {
    M_REG_FLOAT   = 4'h0,
    M_REG_CPU     = 4'h1,
    M_REG_REL     = 4'h2,
    M_FRAME       = 4'h3,
    M_STACK       = 4'h4,
    M_STATIC      = 4'h5,
    M_PROG        = 4'h6,
    M_MREL_FRAME  = 4'h7,
    M_MREL_STACK  = 4'h8,
    M_MREL_STATIC = 4'h9,
    M_IMM         = 4'hA,
    M_ABS         = 4'hB,
    M_EXT         = 4'hC,
    M_TOS         = 4'hD,
    M_RSVD        = 4'hE
  } oamd_method_t;

  typedef struct packed {
    oamd_state_t              st;
    logic [2:0]               step;
    logic [1:0]               used;
    logic [1:0]               flt;
    logic [1:0]               wr;
    logic [1:0]               dbl;
    logic [1:0][4:0]          gen;
    logic [1:0][4:0]          mode;
    logic [1:0][2:0]          idx;
    logic [1:0]               dleft;
    logic                     dsel;
    logic [3:0]               bcnt;
    logic [3:0]               blen;
    logic [3:0]               imm_len;
    logic [1:0]               impl_left;
    logic [63:0]              acc;
    logic [1:0][1:0][31:0]    disp;
    logic [63:0]              imm;
    logic                     imm_vld;
    logic [31:0]              impl;
    oamd_method_t [1:0]       meth;
    logic                     err;
    logic                     done;
  } oamd_state_s_t;
endpackage

// File: rtl/oamd_decoder.sv
// operand addressing mode decoder: gen fields, index bytes, disp/imm stream
//
// Summary of operation
// (RL1) basic instruction carries up to two gen fields
// (RL2) only immediates reach the FPU from stream
// (RL3) scaled index gen adds an index byte
// (RL4) disp/imm fields follow all index bytes
// (RL5) displacement length in top bits, signed value
// (RL6) immediate length comes from the opcode
// (RL7) disp/imm assembled most significant byte first
// (RL8) implied extensions come after all modes
// (RL9) codes 0-7 select register directly
// (RL10) codes 8-15: general register plus displacement
// (RL11) codes 24-27: frame/stack/static/pc plus displacement
// (RL12) codes 16-18: pointer at disp1 plus base, plus disp2
// (RL13) code 20 immediate, never for written operand
// (RL14) code 21 displacement is the address
// (RL15) code 22 link table pointer plus disp2
// (RL16) code 23 top of stack, push/pop
// (RL17) codes 28-31 add scaled index to base
// (RL18) code 19 reserved, no meaning
// (RL19) double float register uses even/odd pair
// (RL20) flag reserved code or illegal index base
`timescale 1ns/100ps
`include "oamd_regs.svh"

module oamd_decoder (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  start_i,
  input  wire logic [1:0]            gen_used_i,
  input  wire logic [4:0]            gen1_i,
  input  wire logic [4:0]            gen2_i,
  input  wire logic [1:0]            float_i,
  input  wire logic [1:0]            write_i,
  input  wire logic [1:0]            double_i,
  input  wire logic [3:0]            imm_bytes_i,
  input  wire logic [1:0]            implied_cnt_i,
  input  wire logic                  byte_valid_i,
  input  wire logic [7:0]            byte_i,
  output logic                       byte_ready_o,
  output logic                       busy_o,
  output logic                       done_o,
  output logic                       decode_err_o,
  output oamd_pkg::oamd_method_t [1:0] method_o,
  output logic [1:0][2:0]            reg_num_o,
  output logic [1:0][2:0]            pair_hi_o,
  output logic [1:0]                 scaled_o,
  output logic [1:0][3:0]            scale_o,
  output logic [1:0][2:0]            index_reg_o,
  output logic [1:0]                 push_o,
  output logic [1:0]                 pop_o,
  output logic [1:0][31:0]           disp1_o,
  output logic [1:0][31:0]           disp2_o,
  output logic [63:0]                imm_o,
  output logic                       imm_valid_o,
  output logic [31:0]                implied_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_scaled(input logic [4:0] g);
    return g[4:2] == 3'b111; // RL17
  endfunction

  // number of displacements a mode pulls from the stream
  function automatic logic [1:0] ndisp(input logic [4:0] g);
    logic [1:0] r;
    r = 2'h0;
    if (g[4:3] == 2'b01 || g[4:2] == 3'b110) begin
      r = 2'h1; // RL10 RL11
    end else if (g == 5'h15) begin
      r = 2'h1; // RL14
    end else if (g == 5'h10 || g == 5'h11 || g == 5'h12 || g == 5'h16) begin
      r = 2'h2; // RL12 RL15
    end
    return r;
  endfunction

  // displacement size sits in the top bits of its first byte
  function automatic logic [3:0] dlen(input logic [7:0] b);
    logic [3:0] r;
    r = `OAMD_DLEN_4;
    if (!b[7]) begin
      r = `OAMD_DLEN_1;
    end else if (!b[6]) begin
      r = `OAMD_DLEN_2;
    end
    return r; // RL5
  endfunction

  function automatic logic [31:0] sext(input logic [3:0] len, input logic [31:0] v);
    logic [31:0] r;
    r = {{2{v[29]}}, v[29:0]};
    if (len == `OAMD_DLEN_1) begin
      r = {{25{v[6]}}, v[6:0]};
    end else if (len == `OAMD_DLEN_2) begin
      r = {{18{v[13]}}, v[13:0]};
    end
    return r; // RL5
  endfunction

  function automatic oamd_pkg::oamd_method_t meth_of(input logic [4:0] g,
                                                     input logic flt);
    oamd_pkg::oamd_method_t m;
    m = oamd_pkg::M_RSVD;
    if (g <= `OAMD_GEN_REG_TOP) begin
      m = flt ? oamd_pkg::M_REG_FLOAT : oamd_pkg::M_REG_CPU; // RL9
    end else if (g[4:3] == 2'b01) begin
      m = oamd_pkg::M_REG_REL; // RL10
    end else begin
      case (g)
        5'h18: m = oamd_pkg::M_FRAME; // RL11
        5'h19: m = oamd_pkg::M_STACK;
        5'h1A: m = oamd_pkg::M_STATIC;
        5'h1B: m = oamd_pkg::M_PROG;
        5'h10: m = oamd_pkg::M_MREL_FRAME; // RL12
        5'h11: m = oamd_pkg::M_MREL_STACK;
        5'h12: m = oamd_pkg::M_MREL_STATIC;
        5'h14: m = oamd_pkg::M_IMM; // RL13
        5'h15: m = oamd_pkg::M_ABS; // RL14
        5'h16: m = oamd_pkg::M_EXT; // RL15
        5'h17: m = oamd_pkg::M_TOS; // RL16
        default: m = oamd_pkg::M_RSVD; // RL18
      endcase
    end
    return m;
  endfunction

  // ****************************************
  // state
  // ****************************************
  oamd_pkg::oamd_state_s_t s_r;
  oamd_pkg::oamd_state_s_t s_nxt;
  logic                    o;
  logic                    take;
  logic [63:0]             nb;
  logic [3:0]              len;
  logic [3:0]              cnt1;
  logic [31:0]             val;
  logic [2:0]              step1;
  logic [4:0]              base;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    o = s_r.step[0];
    step1 = 3'(s_r.step + 3'h1);
    nb = {s_r.acc[55:0], byte_i}; // RL7
    cnt1 = 4'(s_r.bcnt + 4'h1);
    len = (s_r.bcnt == 4'h0) ? dlen(byte_i) : s_r.blen;
    val = sext(len, nb[31:0]);
    base = byte_i[`OAMD_IDX_MODE_MSB:`OAMD_IDX_MODE_LSB];
    take = byte_valid_i && (s_r.st == oamd_pkg::S_IDX || s_r.st == oamd_pkg::S_DISP
                            || s_r.st == oamd_pkg::S_IMM);
    unique case (s_r.st)
      oamd_pkg::S_IDLE: begin
        if (start_i) begin // RL1
          s_nxt.st = oamd_pkg::S_SEEK;
          s_nxt.step = 3'h0;
          s_nxt.used = gen_used_i;
          s_nxt.flt = float_i;
          s_nxt.wr = write_i;
          s_nxt.dbl = double_i;
          s_nxt.gen = {gen2_i, gen1_i};
          s_nxt.mode = {gen2_i, gen1_i};
          s_nxt.idx = '0;
          s_nxt.imm_len = imm_bytes_i; // RL6
          s_nxt.impl_left = implied_cnt_i;
          s_nxt.disp = '0;
          s_nxt.imm = '0;
          s_nxt.imm_vld = 1'b0;
          s_nxt.impl = '0;
          s_nxt.err = (gen_used_i[0] && gen1_i == `OAMD_GEN_RSVD) // RL20
                   || (gen_used_i[1] && gen2_i == `OAMD_GEN_RSVD)
                   || (gen_used_i[0] && write_i[0] && gen1_i == `OAMD_GEN_IMM) // RL13
                   || (gen_used_i[1] && write_i[1] && gen2_i == `OAMD_GEN_IMM);
        end
      end
      oamd_pkg::S_SEEK: begin
        case (s_r.step)
          3'h0, 3'h1: begin
            if (s_r.used[o] && is_scaled(s_r.gen[o])) begin
              s_nxt.st = oamd_pkg::S_IDX; // RL3
            end else begin
              s_nxt.step = step1;
            end
          end
          3'h2, 3'h3: begin // RL4
            s_nxt.bcnt = 4'h0;
            s_nxt.acc = '0;
            if (!s_r.used[o]) begin
              s_nxt.step = step1;
            end else if (s_r.mode[o] == `OAMD_GEN_IMM) begin
              s_nxt.st = oamd_pkg::S_IMM; // RL2
              s_nxt.blen = s_r.imm_len;
            end else if (ndisp(s_r.mode[o]) != 2'h0) begin
              s_nxt.st = oamd_pkg::S_DISP;
              s_nxt.dleft = ndisp(s_r.mode[o]);
              s_nxt.dsel = 1'b0;
            end else begin
              s_nxt.step = step1;
            end
          end
          `OAMD_STEP_IMPL: begin
            s_nxt.bcnt = 4'h0;
            if (s_r.impl_left != 2'h0) begin
              s_nxt.st = oamd_pkg::S_DISP; // RL8
              s_nxt.dleft = 2'h1;
            end else begin
              s_nxt.step = step1;
            end
          end
          default: begin
            s_nxt.st = oamd_pkg::S_IDLE;
            s_nxt.done = 1'b1;
            s_nxt.meth[0] = meth_of(s_r.mode[0], s_r.flt[0]);
            s_nxt.meth[1] = meth_of(s_r.mode[1], s_r.flt[1]);
          end
        endcase
      end
      oamd_pkg::S_IDX: begin
        if (take) begin // RL3
          s_nxt.idx[o] = byte_i[`OAMD_IDX_REG_MSB:0];
          s_nxt.mode[o] = base;
          if (base == `OAMD_GEN_RSVD || base == `OAMD_GEN_IMM || is_scaled(base)) begin
            s_nxt.err = 1'b1; // RL20 RL17
          end
          s_nxt.step = step1;
          s_nxt.st = oamd_pkg::S_SEEK;
        end
      end
      oamd_pkg::S_DISP: begin
        if (take) begin
          s_nxt.blen = len;
          s_nxt.acc = nb;
          s_nxt.bcnt = cnt1;
          if (cnt1 == len) begin
            s_nxt.bcnt = 4'h0;
            if (s_r.step == `OAMD_STEP_IMPL) begin
              s_nxt.impl = val; // RL8
              s_nxt.impl_left = 2'(s_r.impl_left - 2'h1);
              s_nxt.st = oamd_pkg::S_SEEK;
            end else begin
              s_nxt.disp[o][s_r.dsel] = val; // RL5
              s_nxt.dsel = 1'b1;
              s_nxt.dleft = 2'(s_r.dleft - 2'h1);
              if (s_r.dleft == 2'h1) begin
                s_nxt.step = step1;
                s_nxt.st = oamd_pkg::S_SEEK;
              end
            end
          end
        end
      end
      oamd_pkg::S_IMM: begin
        if (take) begin
          s_nxt.acc = nb; // RL7
          s_nxt.bcnt = cnt1;
          if (cnt1 >= s_r.blen) begin // RL6
            s_nxt.imm = nb;
            s_nxt.imm_vld = 1'b1;
            s_nxt.step = step1;
            s_nxt.st = oamd_pkg::S_SEEK;
          end
        end
      end
      default: s_nxt.st = oamd_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '{st: oamd_pkg::S_IDLE, step: 3'h0, meth: '{oamd_pkg::M_RSVD, oamd_pkg::M_RSVD},
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign byte_ready_o = s_r.st == oamd_pkg::S_IDX || s_r.st == oamd_pkg::S_DISP
                     || s_r.st == oamd_pkg::S_IMM;
  assign busy_o       = s_r.st != oamd_pkg::S_IDLE;
  assign done_o       = s_r.done;
  assign decode_err_o = s_r.err;
  assign method_o     = s_r.meth;
  assign imm_o        = s_r.imm;
  assign imm_valid_o  = s_r.imm_vld;
  assign implied_o    = s_r.impl;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      reg_num_o[i]   = s_r.mode[i][2:0]; // RL9 RL10
      // odd half of a double; caller must name the even register
      pair_hi_o[i]   = {s_r.mode[i][2:1], 1'b1}; // RL19
      scaled_o[i]    = s_r.used[i] && is_scaled(s_r.gen[i]);
      scale_o[i]     = scaled_o[i] ? 4'(4'h1 << s_r.gen[i][1:0]) : 4'h1; // RL17
      index_reg_o[i] = s_r.idx[i];
      push_o[i]      = s_r.meth[i] == oamd_pkg::M_TOS && s_r.wr[i]; // RL16
      pop_o[i]       = s_r.meth[i] == oamd_pkg::M_TOS && !s_r.wr[i];
      disp1_o[i]     = s_r.disp[i][0];
      disp2_o[i]     = s_r.disp[i][1];
    end
  end

endmodule

// File: bench/oamd_checker.sv
// assertion checker for the operand addressing mode decoder
`timescale 1ns/100ps
module oamd_checker (
  input wire logic                         clk_i,
  input wire logic                         reset_n_i,
  input wire logic                         start_i,
  input wire logic [1:0]                   gen_used_i,
  input wire logic [4:0]                   gen1_i,
  input wire logic [4:0]                   gen2_i,
  input wire logic [1:0]                   implied_cnt_i,
  input wire logic                         byte_valid_i,
  input wire logic                         byte_ready_o,
  input wire logic                         busy_o,
  input wire logic                         done_o,
  input wire logic                         decode_err_o,
  input wire oamd_pkg::oamd_method_t [1:0] method_o,
  input wire logic [1:0]                   scaled_o,
  input wire logic [1:0][3:0]              scale_o,
  input wire logic [1:0]                   push_o,
  input wire logic [1:0]                   pop_o,
  input wire logic                         imm_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic go;
  // only starts that need no extension bytes have a fixed latency
  assign go = start_i && !busy_o && gen_used_i == 2'b11 && gen2_i <= 5'h07
              && implied_cnt_i == 2'h0;
  a_start_busy: assert property (start_i && !busy_o |=> busy_o)
    else $error("start not taken");
  a_done_pulse: assert property (done_o && !start_i |=> !done_o && !busy_o)
    else $error("done longer than one cycle");
  // start edge, five seek steps, finish step, then the registered done pulse
  a_reg_direct: assert property (go && gen1_i <= 5'h07 |-> ##7 done_o && !decode_err_o && method_o[0][3:1] == 3'h0)
    else $error("register mode wrong");
  a_rsvd_flag: assert property (go && gen1_i == 5'h13 |-> ##7 done_o && decode_err_o)
    else $error("reserved code not flagged");
  a_idle_ready: assert property (!busy_o |-> !byte_ready_o)
    else $error("byte ready while idle");
  a_ready_hold: assert property (byte_ready_o && !byte_valid_i |=> byte_ready_o)
    else $error("byte ready dropped");
  a_tos_only: assert property (done_o && method_o[0] != oamd_pkg::M_TOS |-> !push_o[0] && !pop_o[0])
    else $error("push or pop outside top of stack");
  a_scale_set: assert property (done_o |-> $onehot(scale_o[0]) && (scaled_o[0] || scale_o[0] == 4'h1))
    else $error("scale wrong");
  a_imm_valid: assert property (done_o && !decode_err_o && method_o[0] == oamd_pkg::M_IMM |-> imm_valid_o)
    else $error("immediate not valid");
  c_err: cover property (done_o && decode_err_o);
  c_imm: cover property (done_o && imm_valid_o);
  c_take: cover property (byte_valid_i && byte_ready_o);
endmodule
bind oamd_decoder oamd_checker u_chk (.clk_i, .reset_n_i, .start_i, .gen_used_i, .gen1_i,
  .gen2_i, .implied_cnt_i, .byte_valid_i, .byte_ready_o, .busy_o, .done_o, .decode_err_o,
  .method_o, .scaled_o, .scale_o, .push_o, .pop_o, .imm_valid_o);

// File: bench/oamd_host.sv
// host cpu model feeding extension bytes to the decoder
`timescale 1ns/100ps
module oamd_host (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       byte_ready_i,
  input  wire logic       slow_i,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  logic [7:0] q[$];
  logic       took = 1'b0;
  logic       gap = 1'b0;
  initial byte_valid_o = 1'b0;
  initial byte_o = 8'h00;
  always @(posedge clk_i) took = byte_valid_o && byte_ready_i && reset_n_i;
  // only index, immediate and extension bytes, msb first, reach the decoder
  always @(negedge clk_i) begin
    if (took && q.size() != 0) void'(q.pop_front());
    gap <= ~gap;
    if (byte_valid_o && !took && q.size() != 0) begin
      byte_o <= q[0];
    end else if (q.size() != 0 && !(slow_i && gap)) begin
      byte_valid_o <= 1'b1;
      byte_o <= q[0];
    end else begin
      byte_valid_o <= 1'b0;
      byte_o <= ~byte_o;
    end
  end
endmodule

// File: bench/oamd_decoder_tb.sv
// self-checking bench for the operand addressing mode decoder
`timescale 1ns/100ps
module oamd_decoder_tb;
  typedef struct {logic [3:0] meth, sc, ix; logic err; logic [1:0] pp; logic [2:0] rn;
                  logic [31:0] d1, d2, impl; logic [63:0] imm;} oamd_exp_t;
  logic                         clk_i, reset_n_i, start_i, byte_valid_i, slow;
  logic [1:0]                   gen_used_i, float_i, write_i, implied_cnt_i;
  logic [4:0]                   gen1_i, gen2_i;
  logic [3:0]                   imm_bytes_i;
  logic [7:0]                   byte_i;
  logic                         byte_ready_o, busy_o, done_o, decode_err_o, imm_valid_o;
  oamd_pkg::oamd_method_t [1:0] method_o;
  logic [1:0][2:0]              reg_num_o, pair_hi_o, index_reg_o;
  logic [1:0]                   scaled_o, push_o, pop_o;
  logic [1:0][3:0]              scale_o;
  logic [1:0][31:0]             disp1_o, disp2_o;
  logic [63:0]                  imm_o;
  logic [31:0]                  implied_o;
  int                           num_errors, total_checks, seed;
  oamd_exp_t                    exq[$];
  oamd_exp_t                    ex;

  oamd_decoder DUT (.clk_i, .reset_n_i, .start_i, .gen_used_i, .gen1_i, .gen2_i, .float_i,
    .write_i, .double_i(2'b00), .imm_bytes_i, .implied_cnt_i, .byte_valid_i, .byte_i,
    .byte_ready_o, .busy_o, .done_o, .decode_err_o, .method_o, .reg_num_o, .pair_hi_o,
    .scaled_o, .scale_o, .index_reg_o, .push_o, .pop_o, .disp1_o, .disp2_o, .imm_o,
    .imm_valid_o, .implied_o);
  oamd_host host (.clk_i, .reset_n_i, .byte_ready_i(byte_ready_o), .slow_i(slow),
    .byte_valid_o(byte_valid_i), .byte_o(byte_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [3:0] meth_of(input logic [4:0] m, input logic f);
    if (m < 5'h08) return f ? 4'h0 : 4'h1;
    if (m < 5'h10) return 4'h2;
    if (m < 5'h13) return 4'(m - 5'h09);
    if (m < 5'h18) return 4'(m - 5'h0A);
    return 4'(m - 5'h15);
  endfunction

  // random length displacement, size code in the top bits of the first byte
  task automatic put_disp(output logic [31:0] v);
    logic [31:0] r, w;
    int          n;
    r = $random(seed);
    n = r[31] ? 4 : r[30] ? 2 : 1;
    v = (n == 1) ? {{25{r[6]}}, r[6:0]} : (n == 2) ? {{18{r[13]}}, r[13:0]}
                                       : {{2{r[29]}}, r[29:0]};
    w = (n == 1) ? {25'h0, r[6:0]} : (n == 2) ? {16'h0, 2'b10, r[13:0]} : {2'b11, r[29:0]};
    for (int k = n - 1; k >= 0; k--) host.q.push_back(w[8*k +: 8]);
  endtask

  task automatic op(input logic [4:0] c, input logic [4:0] base, input logic f, input logic w,
                    input logic impl);
    oamd_exp_t   e;
    logic [4:0]  m;
    logic [63:0] r;
    logic [3:0]  ib;
    int          t;
    e = '{default: '0};
    e.sc = 4'h1;
    m = c;
    r = {$random(seed), $random(seed)};
    ib = 4'h1 << r[1:0];
    host.q.delete();
    if (c[4:2] == 3'b111) begin
      e.sc = 4'h1 << c[1:0];
      e.ix = 4'hD;
      m = base;
      host.q.push_back({base, 3'h5});
    end
    e.meth = meth_of(m, f);
    e.rn = m[2:0];
    e.err = c == 5'h13 || m == 5'h13 || (m == 5'h14 && (w || m != c))
            || (c[4:2] == 3'b111 && m[4:2] == 3'b111);
    e.pp = (m == 5'h17) ? {w, !w} : 2'b00;
    if (m == 5'h14) begin
      e.imm = r >> (64 - 8 * ib);
      for (int k = ib - 1; k >= 0; k--) host.q.push_back(e.imm[8*k +: 8]);
    end else if (m inside {[5'h08:5'h0F], [5'h18:5'h1B], 5'h15}) begin
      put_disp(e.d1);
    end else if (m inside {[5'h10:5'h12], 5'h16}) begin
      put_disp(e.d1);
      put_disp(e.d2);
    end
    if (impl) put_disp(e.impl);
    exq.push_back(e);
    @(negedge clk_i);
    start_i <= 1'b1;
    gen1_i <= c;
    gen2_i <= {2'b00, r[34:32]};
    float_i <= {r[40], f};
    write_i <= {1'b1, w};
    imm_bytes_i <= ib;
    implied_cnt_i <= {1'b0, impl};
    @(negedge clk_i);
    start_i <= 1'b0;
    for (t = 0; t < 200 && done_o !== 1'b1; t++) @(negedge clk_i);
    if (t == 200) begin
      num_errors++;
      conclude();
    end
  endtask

  always @(negedge clk_i) begin
    if (done_o === 1'b1 && exq.size() != 0) begin
      ex = exq.pop_front();
      chk("error", decode_err_o, ex.err);
      if (!ex.err) begin
        chk("method", method_o[0], ex.meth);
        chk("disp", {disp2_o[0], disp1_o[0]}, {ex.d2, ex.d1});
        chk("scale", {scale_o[0], push_o[0], pop_o[0]}, {ex.sc, ex.pp});
        chk("index", {scaled_o[0], index_reg_o[0]}, ex.ix);
        if (ex.impl != 32'h0) chk("implied", implied_o, ex.impl);
        if (ex.meth == 4'hA) chk("imm", imm_o, ex.imm);
        if (ex.meth < 4'h3) chk("regnum", reg_num_o[0], ex.rn);
        if (ex.meth < 4'h2) chk("pair", pair_hi_o[0], {ex.rn[2:1], 1'b1});
      end
    end
  end

  initial begin
    seed = 32'h770f;
    num_errors = 0;
    total_checks = 0;
    slow = 1'b0;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    gen_used_i = 2'b11;
    {gen1_i, gen2_i, float_i, write_i, implied_cnt_i} = '0;
    imm_bytes_i = 4'h1;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 32; i++) begin
      slow = i[2];
      op(5'(i), {2'b01, i[2:0]}, i[1], 1'b0, i[3]);
    end
    op(5'h17, 5'h00, 1'b0, 1'b1, 1'b0);
    op(5'h14, 5'h00, 1'b1, 1'b1, 1'b0);
    op(5'h1D, 5'h13, 1'b0, 1'b0, 1'b0);
    op(5'h1E, 5'h14, 1'b0, 1'b0, 1'b0);
    op(5'h1F, 5'h1C, 1'b0, 1'b0, 1'b0);
    repeat (40) begin
      slow = $random(seed);
      op(5'($random(seed)), 5'($random(seed)) & 5'h1B, 1'($random(seed)), 1'($random(seed)),
         1'($random(seed)));
    end
    conclude();
  end
endmodule
